// ### common/swe_pkg.sv
// swe_pkg: constants and types shared by the serial eeprom device and host ends.
// assumes a single 40 MHz system clock on both ends.
package swe_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS      = 25;
  localparam int PROG_TIME_MS       = 5;
  localparam int PROG_CYCLES        = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MIN_SEL_LOW_NS     = 250;
  localparam int MIN_SEL_LOW_CYC    = (MIN_SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SK_HALF_NS         = 250;
  localparam int SK_HALF_CYC        = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame geometry
  localparam int OPC_W              = 2;
  localparam int ADDR_W16           = 10;
  localparam int ADDR_W8            = 11;
  localparam int DATA_W16           = 16;
  localparam int DATA_W8            = 8;
  localparam int FRAME_W            = 29;
  localparam int WORDS              = 512;

  // opcodes and special codes (top two address bits)
  localparam logic [1:0] OPC_READ    = 2'h2;
  localparam logic [1:0] OPC_ERASE   = 2'h3;
  localparam logic [1:0] OPC_WRITE   = 2'h1;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] SPC_WEN     = 2'h3;
  localparam logic [1:0] SPC_WDS     = 2'h0;
  localparam logic [1:0] SPC_ERASE_ALL_CMD    = 2'h2;
  localparam logic [1:0] SPC_WRITE_ALL_CMD    = 2'h1;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // host register map and fields
  localparam logic [2:0] REG_CMD     = 3'h0;
  localparam logic [2:0] REG_ADDR    = 3'h1;
  localparam logic [2:0] REG_WDATA   = 3'h2;
  localparam logic [2:0] REG_RDATA   = 3'h3;
  localparam logic [2:0] REG_STATUS  = 3'h4;
  localparam int CMD_X16_BIT         = 3;
  localparam int STAT_BUSY_BIT       = 0;
  localparam int STAT_READY_BIT      = 1;
  localparam logic       CMD_X16_RST = 1'b1;

  typedef enum logic [2:0] {
    CMD_READ, CMD_ERASE, CMD_WRITE, CMD_WEN, CMD_WDS, CMD_ERASE_ALL_CMD, CMD_WRITE_ALL_CMD
  } swe_cmd_e;

endpackage

// ### common/swe_link_if.sv
// swe_link_if: four-wire serial link between host and eeprom device.
// the data-out wire idles high through a modelled pull-up when not driven.
`timescale 1ns/1ps
interface swe_link_if;
  logic cs;
  logic sk;
  logic di;
  logic dout;
  logic dout_oe;
  logic do_line;

  assign do_line = dout_oe ? dout : 1'b1;

  modport dev (input cs, input sk, input di, output dout, output dout_oe);
  modport host (output cs, output sk, output di, input do_line);
endinterface

// ### hdl/swe_dev.sv
// swe_dev: serial eeprom device end, decoder, array and self-timed cycle.
// assumes link pins are asynchronous to REF_CLK_I; all are synchronised.
// Operation
// - frame: start one, opcode, address, data
// - opcodes 10 read, 11 erase, 01 write, specials
// - instruction 13 bits x16, 14 bits x8
// - address 10/11 bits, data 16/8 bits
// - host sends top address bit defined; ignored
// - input bits sampled at clock rising edge
// - output released except read or status
// - status low busy, high ready after select
// - dummy one releases output at falling edge
// - read gives dummy zero then msb first
// - read bits change on rising clock edge
// - sequential read continues, wraps, no dummy
// - select falling after write starts self-timed store
// - write clears location first automatically
// - erase sets addressed location to all ones
// - powers up write disabled until enable
// - enable persists until disable command
// - reads work regardless of enable state
// - erase all sets every bit one
// - write all stores word everywhere
// - select falls before next rising edge only
// - org high selects x16, low x8
`timescale 1ns/1ps
module swe_dev
  import swe_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)(
  // clock and reset
  input  wire logic REF_CLK_I,
  input  wire logic RST_I,
  // organisation strap
  input  wire logic ORG_I,
  // link
  swe_link_if.dev   LINK,
  // status
  output wire logic BUSY_O,
  output wire logic WEN_O
);

  localparam int TW = $clog2(PROG_CYC + 1);

  if (PROG_CYC < 1)
  begin : g_chk
    $error("PROG_CYC must be at least one");
  end

  typedef enum {D_IDLE, D_RX, D_READ, D_DONE} swe_dst_e;
  typedef enum logic [1:0] {P_WRITE, P_ERASE, P_ERASE_ALL_CMD, P_WRITE_ALL_CMD} swe_pop_e;

  typedef struct packed {
    logic          cs_m;
    logic          cs_s;
    logic          cs_d;
    logic          sk_m;
    logic          sk_s;
    logic          sk_d;
    logic          di_m;
    logic          di_s;
    logic          org_m;
    logic          org_s;
    swe_dst_e      st;
    logic          x16;
    logic [5:0]    cnt;
    logic [1:0]    opc;
    logic [10:0]   addr;
    logic [15:0]   data;
    swe_pop_e      pk;
    logic          armed;
    logic          wen;
    logic          busy;
    logic [TW-1:0] timer;
    logic          stat_pend;
    logic          stat_on;
    logic          hiz_req;
    logic          dout;
    logic          doe;
    logic [15:0]   osr;
    logic [4:0]    bitc;
  } swe_dev_s;

  swe_dev_s r_reg;
  swe_dev_s r_next;
  logic     mem_we;
  logic [15:0] mem [WORDS];

  // word at an address, left-justified; x8 odd byte sits in the high half
  function automatic logic [15:0] rd_word(input logic [10:0] a, input logic x16);
    logic [15:0] w;
    w = x16 ? mem[a[8:0]] : mem[a[9:1]];
    if (x16)
      return w;
    return a[0] ? {w[15:8], 8'h00} : {w[7:0], 8'h00};
  endfunction

  function automatic logic [10:0] next_addr(input logic [10:0] a, input logic x16);
    if (x16)
      return {2'b00, a[8:0] + 9'h001};
    return {1'b0, a[9:0] + 10'h001};
  endfunction

  always_comb
  begin
    logic        sk_rise;
    logic        sk_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic [10:0] a_new;
    logic [5:0]  aw;
    logic [5:0]  dw;
    logic [1:0]  spc;
    sk_rise = 1'b0;
    sk_fall = 1'b0;
    cs_rise = 1'b0;
    cs_fall = 1'b0;
    a_new   = '0;
    aw      = '0;
    dw      = '0;
    spc     = '0;
    r_next  = r_reg;
    mem_we  = 1'b0;
    // two-stage synchronisers; the second stage and its delayed copy (cs_d, sk_d) are read below
    r_next.cs_m  = LINK.cs;
    r_next.cs_s  = r_reg.cs_m;
    r_next.cs_d  = r_reg.cs_s;
    r_next.sk_m  = LINK.sk;
    r_next.sk_s  = r_reg.sk_m;
    r_next.sk_d  = r_reg.sk_s;
    r_next.di_m  = LINK.di;
    r_next.di_s  = r_reg.di_m;
    r_next.org_m = ORG_I;
    r_next.org_s = r_reg.org_m;
    sk_rise = r_reg.sk_s & ~r_reg.sk_d;
    sk_fall = ~r_reg.sk_s & r_reg.sk_d;
    cs_rise = r_reg.cs_s & ~r_reg.cs_d;
    cs_fall = ~r_reg.cs_s & r_reg.cs_d;
    aw = r_reg.x16 ? 6'(ADDR_W16) : 6'(ADDR_W8);
    dw = r_reg.x16 ? 6'(DATA_W16) : 6'(DATA_W8);
    a_new = {r_reg.addr[9:0], r_reg.di_s};
    // top address bit is stored but never used for indexing
    spc = r_reg.x16 ? a_new[9:8] : a_new[10:9];

    if (r_reg.busy)
    begin
      if (r_reg.timer == TW'(PROG_CYC - 1))
        r_next.busy = 1'b0;
      else
        r_next.timer = r_reg.timer + TW'(1);
    end

    if (!r_reg.cs_s)
    begin
      // deselect ends everything except a properly armed trigger
      r_next.st      = D_IDLE;
      r_next.doe     = 1'b0;
      r_next.stat_on = 1'b0;
      r_next.hiz_req = 1'b0;
      r_next.armed   = 1'b0;
      if (cs_fall && r_reg.st == D_DONE && r_reg.armed && !r_reg.busy)
      begin
        mem_we           = 1'b1;
        r_next.busy      = 1'b1;
        r_next.timer     = '0;
        r_next.stat_pend = 1'b1;
      end
    end
    else
    begin
      if (cs_rise && r_reg.stat_pend)
      begin
        r_next.stat_on = 1'b1;
        r_next.doe     = 1'b1;
      end
      if (r_reg.stat_on || (cs_rise && r_reg.stat_pend))
      begin
        r_next.dout = ~r_reg.busy;
        if (sk_rise && r_reg.di_s)
          r_next.hiz_req = 1'b1;
        if (sk_fall && r_reg.hiz_req)
        begin
          r_next.doe       = 1'b0;
          r_next.stat_on   = 1'b0;
          r_next.stat_pend = 1'b0;
          r_next.hiz_req   = 1'b0;
        end
      end
      // while the cycle runs the decoder stays idle so the array is left alone
      if (sk_rise && !r_reg.busy)
      begin
        unique case (r_reg.st)
          D_IDLE:
          begin
            if (r_reg.di_s)
            begin
              r_next.st   = D_RX;
              r_next.cnt  = '0;
              r_next.x16  = r_reg.org_s;
              r_next.opc  = '0;
              r_next.addr = '0;
              r_next.data = '0;
            end
          end
          D_RX:
          begin
            r_next.cnt = r_reg.cnt + 6'h01;
            if (r_reg.cnt < 6'(OPC_W))
              r_next.opc = {r_reg.opc[0], r_reg.di_s};
            else if (r_reg.cnt < 6'(OPC_W) + aw)
              r_next.addr = a_new;
            else
              r_next.data = {r_reg.data[14:0], r_reg.di_s};
            if (r_reg.cnt == 6'(OPC_W) + aw - 6'h01)
            begin
              unique case (r_reg.opc)
                OPC_READ:
                begin
                  // no enable check: reads always run
                  r_next.st   = D_READ;
                  r_next.doe  = 1'b1;
                  r_next.dout = 1'b0;
                  r_next.osr  = rd_word(a_new, r_reg.x16);
                  r_next.bitc = '0;
                end
                OPC_ERASE:
                begin
                  r_next.pk    = P_ERASE;
                  r_next.armed = r_reg.wen;
                  r_next.st    = D_DONE;
                end
                OPC_WRITE:
                  r_next.pk = P_WRITE;
                OPC_SPECIAL:
                begin
                  unique case (spc)
                    SPC_WEN:
                    begin
                      r_next.wen = 1'b1;
                      r_next.st  = D_DONE;
                    end
                    SPC_WDS:
                    begin
                      r_next.wen = 1'b0;
                      r_next.st  = D_DONE;
                    end
                    SPC_ERASE_ALL_CMD:
                    begin
                      r_next.pk    = P_ERASE_ALL_CMD;
                      r_next.armed = r_reg.wen;
                      r_next.st    = D_DONE;
                    end
                    SPC_WRITE_ALL_CMD:
                      r_next.pk = P_WRITE_ALL_CMD;
                  endcase
                end
              endcase
            end
            if (r_reg.cnt == 6'(OPC_W) + aw + dw - 6'h01)
            begin
              r_next.armed = r_reg.wen;
              r_next.st    = D_DONE;
            end
          end
          D_READ:
          begin
            r_next.dout = r_reg.osr[15];
            r_next.osr  = {r_reg.osr[14:0], 1'b0};
            r_next.bitc = r_reg.bitc + 5'h01;
            if (r_reg.bitc == 5'(dw - 6'h01))
            begin
              r_next.addr = next_addr(r_reg.addr, r_reg.x16);
              r_next.osr  = rd_word(next_addr(r_reg.addr, r_reg.x16), r_reg.x16);
              r_next.bitc = '0;
            end
          end
          D_DONE:
            r_next.armed = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      r_reg    <= '0;
      r_reg.st <= D_IDLE;
      r_reg.pk <= P_WRITE;
    end
    else
      r_reg <= r_next;
  end

  // array has no reset: it stands for nonvolatile storage
  always_ff @(posedge REF_CLK_I)
  begin
    if (mem_we)
    begin
      unique case (r_reg.pk)
        P_WRITE:
          if (r_reg.x16)
            mem[r_reg.addr[8:0]] <= r_reg.data;
          else if (r_reg.addr[0])
            mem[r_reg.addr[9:1]][15:8] <= r_reg.data[7:0];
          else
            mem[r_reg.addr[9:1]][7:0] <= r_reg.data[7:0];
        P_ERASE:
          if (r_reg.x16)
            mem[r_reg.addr[8:0]] <= ERASED_WORD;
          else if (r_reg.addr[0])
            mem[r_reg.addr[9:1]][15:8] <= ERASED_WORD[15:8];
          else
            mem[r_reg.addr[9:1]][7:0] <= ERASED_WORD[7:0];
        P_ERASE_ALL_CMD:
          for (int i = 0; i < WORDS; i++)
            mem[i] <= ERASED_WORD;
        P_WRITE_ALL_CMD:
          for (int i = 0; i < WORDS; i++)
            mem[i] <= r_reg.x16 ? r_reg.data : {r_reg.data[7:0], r_reg.data[7:0]};
      endcase
    end
  end

  assign LINK.dout    = r_reg.dout;
  assign LINK.dout_oe = r_reg.doe;
  assign BUSY_O       = r_reg.busy;
  assign WEN_O        = r_reg.wen;

endmodule

// ### hdl/swe_host.sv
// swe_host: host controller that frames commands onto the serial link.
// assumes software drives the plain register port on REF_CLK_I.
`timescale 1ns/1ps
module swe_host
  import swe_pkg::*;
#(
  parameter int HALF_CYC = SK_HALF_CYC,
  parameter int LOW_CYC  = MIN_SEL_LOW_CYC
)(
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // register port
  input  wire logic [2:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output wire logic [15:0] RDATA_O,
  // link
  swe_link_if.host         LINK
);

  if (HALF_CYC < 4 || HALF_CYC > 255 || LOW_CYC < 1 || LOW_CYC > 255)
  begin : g_chk
    $error("HALF_CYC must be 4..255 and LOW_CYC 1..255");
  end

  typedef enum {H_IDLE, H_SHIFT, H_READ, H_CSLOW, H_POLL} swe_hst_e;

  typedef struct packed {
    swe_hst_e             st;
    swe_cmd_e             op;
    logic                 x16;
    logic [10:0]          addr;
    logic [15:0]          wdata;
    logic [15:0]          rdata;
    logic                 ready_seen;
    logic [FRAME_W-1:0]   frame;
    logic [4:0]           nbits;
    logic [4:0]           sent;
    logic [7:0]           div;
    logic                 poll;
    logic                 cs;
    logic                 sk;
    logic                 di;
    logic                 do_m;
    logic                 do_s;
    logic [15:0]          rdata_o;
  } swe_host_s;

  swe_host_s r_reg;
  swe_host_s r_next;

  // left-justified frame; specials carry their code in the top address bits
  function automatic logic [FRAME_W-1:0] frame_f(input swe_cmd_e c, input logic x16,
                                                 input logic [10:0] a, input logic [15:0] d);
    logic [1:0]  opc;
    logic [10:0] af;
    opc = OPC_SPECIAL;
    af  = a;
    unique case (c)
      CMD_READ:  opc = OPC_READ;
      CMD_ERASE: opc = OPC_ERASE;
      CMD_WRITE: opc = OPC_WRITE;
      CMD_WEN:   af  = x16 ? {1'b0, SPC_WEN, 8'h00} : {SPC_WEN, 9'h000};
      CMD_WDS:   af  = x16 ? {1'b0, SPC_WDS, 8'h00} : {SPC_WDS, 9'h000};
      CMD_ERASE_ALL_CMD:  af  = x16 ? {1'b0, SPC_ERASE_ALL_CMD, 8'h00} : {SPC_ERASE_ALL_CMD, 9'h000};
      CMD_WRITE_ALL_CMD:  af  = x16 ? {1'b0, SPC_WRITE_ALL_CMD, 8'h00} : {SPC_WRITE_ALL_CMD, 9'h000};
    endcase
    if (x16)
      return {1'b1, opc, af[9:0], d};
    return {1'b1, opc, af, d[7:0], 7'h00};
  endfunction

  function automatic logic [4:0] nbits_f(input swe_cmd_e c, input logic x16);
    logic [4:0] n;
    n = x16 ? 5'(1 + OPC_W + ADDR_W16) : 5'(1 + OPC_W + ADDR_W8);
    if (c == CMD_WRITE || c == CMD_WRITE_ALL_CMD)
      n = n + (x16 ? 5'(DATA_W16) : 5'(DATA_W8));
    return n;
  endfunction

  always_comb
  begin
    logic busy;
    busy   = r_reg.st != H_IDLE;
    r_next = r_reg;
    r_next.do_m = LINK.do_line;
    r_next.do_s = r_reg.do_m;
    if (WR_I)
    begin
      unique case (ADDR_I)
        REG_CMD:
          if (!busy && WDATA_I[2:0] <= 3'(CMD_WRITE_ALL_CMD))
          begin
            r_next.op    = swe_cmd_e'(WDATA_I[2:0]);
            r_next.x16   = WDATA_I[CMD_X16_BIT];
            r_next.frame = frame_f(swe_cmd_e'(WDATA_I[2:0]), WDATA_I[CMD_X16_BIT],
                                   r_reg.addr, r_reg.wdata);
            r_next.nbits = nbits_f(swe_cmd_e'(WDATA_I[2:0]), WDATA_I[CMD_X16_BIT]);
            r_next.sent  = '0;
            r_next.div   = '0;
            r_next.cs    = 1'b1;
            r_next.sk    = 1'b0;
            r_next.di    = 1'b1;
            r_next.ready_seen = 1'b0;
            r_next.st    = H_SHIFT;
          end
        REG_ADDR:  r_next.addr  = WDATA_I[10:0];
        REG_WDATA: r_next.wdata = WDATA_I;
        default:   ;
      endcase
    end
    if (RD_I)
    begin
      unique case (ADDR_I)
        REG_CMD:    r_next.rdata_o = {12'h000, r_reg.x16, r_reg.op};
        REG_ADDR:   r_next.rdata_o = {5'h00, r_reg.addr};
        REG_WDATA:  r_next.rdata_o = r_reg.wdata;
        REG_RDATA:  r_next.rdata_o = r_reg.rdata;
        REG_STATUS: r_next.rdata_o = {14'h0000, r_reg.ready_seen, busy};
        default:    r_next.rdata_o = 16'h0000;
      endcase
    end
    unique case (r_reg.st)
      H_IDLE: ;
      H_SHIFT, H_READ:
      begin
        r_next.div = r_reg.div + 8'h01;
        if (r_reg.div == 8'(HALF_CYC - 1))
        begin
          r_next.div = '0;
          r_next.sk  = ~r_reg.sk;
          if (r_reg.sk)
          begin
            r_next.sent = r_reg.sent + 5'h01;
            if (r_reg.st == H_READ)
            begin
              // dummy zero went out with the last address bit, so every fall here is data
              r_next.rdata = {r_reg.rdata[14:0], r_reg.do_s};
              if (r_reg.sent == (r_reg.x16 ? 5'(DATA_W16 - 1) : 5'(DATA_W8 - 1)))
              begin
                r_next.cs   = 1'b0;
                r_next.poll = 1'b0;
                r_next.st   = H_CSLOW;
              end
            end
            else if (r_reg.sent == r_reg.nbits - 5'h01)
            begin
              // non-read commands deselect right after the last fall, before any further rise; a read goes on to H_READ
              r_next.sent = '0;
              if (r_reg.op == CMD_READ)
              begin
                r_next.rdata = '0;
                r_next.st    = H_READ;
              end
              else
              begin
                r_next.cs   = 1'b0;
                r_next.poll = !(r_reg.op == CMD_WEN || r_reg.op == CMD_WDS);
                r_next.st   = H_CSLOW;
              end
            end
            else
            begin
              r_next.frame = {r_reg.frame[FRAME_W-2:0], 1'b0};
              r_next.di    = r_reg.frame[FRAME_W-2];
            end
          end
        end
      end
      H_CSLOW:
      begin
        r_next.div = r_reg.div + 8'h01;
        if (r_reg.div == 8'(LOW_CYC - 1))
        begin
          r_next.div = '0;
          r_next.st  = r_reg.poll ? H_POLL : H_IDLE;
          r_next.cs  = r_reg.poll;
        end
      end
      H_POLL:
      begin
        r_next.div = r_reg.div + 8'h01;
        if (r_reg.div >= 8'(HALF_CYC - 1) && r_reg.do_s)
        begin
          r_next.ready_seen = 1'b1;
          r_next.cs   = 1'b0;
          r_next.poll = 1'b0;
          r_next.div  = '0;
          r_next.st   = H_CSLOW;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      r_reg     <= '0;
      r_reg.st  <= H_IDLE;
      r_reg.op  <= CMD_READ;
      r_reg.x16 <= CMD_X16_RST;
    end
    else
      r_reg <= r_next;
  end

  assign LINK.cs  = r_reg.cs;
  assign LINK.sk  = r_reg.sk;
  assign LINK.di  = r_reg.di;
  assign RDATA_O  = r_reg.rdata_o;

endmodule

// ### sim/swe_chk.sv
// swe_chk: assertions on the serial eeprom link and device status.
// assumes the host and device ends face each other on one link.
`timescale 1ns/1ps
module swe_chk #(
  parameter int PROG_CYC = 50
)(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // link wires
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic dout,
  input wire logic dout_oe,
  // device status
  input wire logic BUSY_O,
  input wire logic WEN_O
);
  int busy_cnt;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  // counter stands in for a long repetition
  always_ff @(posedge REF_CLK_I or posedge RST_I)
    if (RST_I) busy_cnt <= 0;
    else busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;

  a_oe_needs_cs: assert property (!cs [*5] |-> !dout_oe)
    else $error("data out driven while deselected");
  a_busy_on_csfall: assert property ($rose(BUSY_O) |-> !cs && $past(!cs))
    else $error("cycle started while selected");
  a_busy_needs_wen: assert property ($rose(BUSY_O) |-> WEN_O)
    else $error("cycle started with writes disabled");
  a_busy_length: assert property ($fell(BUSY_O) |-> busy_cnt == PROG_CYC)
    else $error("cycle length wrong");
  a_status_low: assert property (dout_oe && $past(dout_oe) && BUSY_O && $past(BUSY_O) |-> !dout)
    else $error("status not low while busy");
  a_bit_on_rise: assert property (dout_oe && $past(dout_oe) && $changed(dout)
    && !$past(BUSY_O, 4) |-> sk) else $error("read bit changed with clock low");
  a_release_fall: assert property ($fell(dout_oe) |-> !sk || !cs)
    else $error("release outside clock low");
  a_wen_framed: assert property ($changed(WEN_O) |-> cs && !BUSY_O)
    else $error("enable latch moved outside a frame");
  a_di_steady: assert property ($changed(di) |-> !sk)
    else $error("data in moved while clock high");
  a_cs_low_min: assert property ($fell(cs) |-> !cs [*8])
    else $error("select low time too short");
  a_sk_idle: assert property (!cs |-> !sk)
    else $error("clock runs outside a frame");
endmodule

// ### sim/tb_serial_eeprom_command_port.sv
// tb_serial_eeprom_command_port: host and device joined, driven via host registers.
// assumes x16 organisation and a shortened self-timed cycle.
`timescale 1ns/1ps
module tb_serial_eeprom_command_port;
  import swe_pkg::*;
  localparam int PROG = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        busy;
  logic        wen;
  int          n_errors = 0;
  int          n_tests = 0;

  swe_link_if link_i();
  swe_dev #(.PROG_CYC(PROG)) swe_dev_i (.REF_CLK_I(clk), .RST_I(rst), .ORG_I(1'b1),
    .LINK(link_i), .BUSY_O(busy), .WEN_O(wen));
  swe_host swe_host_i (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK(link_i));
  swe_chk #(.PROG_CYC(PROG)) swe_chk_i (.REF_CLK_I(clk), .RST_I(rst), .cs(link_i.cs),
    .sk(link_i.sk), .di(link_i.di), .dout(link_i.dout), .dout_oe(link_i.dout_oe),
    .BUSY_O(busy), .WEN_O(wen));

  always #12.5 clk = ~clk;

  task wrap_up;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand from the cycle after the strobe until the next read strobe
  task rreg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task op(input swe_cmd_e c, input logic [10:0] a, input logic [15:0] d);
    logic [15:0] s;
    int i;
    wreg(REG_ADDR, {5'h00, a});
    wreg(REG_WDATA, d);
    wreg(REG_CMD, {12'h000, 1'b1, c});
    repeat (3) @(posedge clk);
    for (i = 0; i < 20000; i++)
    begin
      rreg(REG_STATUS, s);
      if (s[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 20000)
    begin
      n_errors++;
      $display("CHECK FAILED host idle expected 0 seen busy");
    end
  endtask

  task rword(input logic [10:0] a, input logic [15:0] e);
    logic [15:0] v;
    op(CMD_READ, a, 16'h0000);
    rreg(REG_RDATA, v);
    chk("read word", e, v);
  endtask

  initial
  begin
    #2000000;
    n_errors++;
    wrap_up;
  end

  initial
  begin
    logic [15:0] v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk("enable after reset", 16'h0000, {15'h0000, wen});
    op(CMD_WEN, 11'h000, 16'h0000);
    chk("enable set", 16'h0001, {15'h0000, wen});
    op(CMD_ERASE_ALL_CMD, 11'h000, 16'h0000);
    rword(11'h005, ERASED_WORD);
    rword(11'h1FF, ERASED_WORD);
    op(CMD_WDS, 11'h000, 16'h0000);
    chk("enable cleared", 16'h0000, {15'h0000, wen});
    op(CMD_WRITE, 11'h005, 16'h1234);
    rword(11'h005, ERASED_WORD);
    op(CMD_WEN, 11'h000, 16'h0000);
    op(CMD_WRITE, 11'h005, 16'hA5C3);
    rword(11'h005, 16'hA5C3);
    op(CMD_WRITE, 11'h005, 16'h5A3C);
    rword(11'h005, 16'h5A3C);
    op(CMD_WRITE, 11'h205, 16'h0F0F);
    rword(11'h005, 16'h0F0F);
    op(CMD_ERASE, 11'h005, 16'h0000);
    rword(11'h005, ERASED_WORD);
    op(CMD_WRITE_ALL_CMD, 11'h000, 16'h3C3C);
    rword(11'h000, 16'h3C3C);
    rword(11'h1FF, 16'h3C3C);
    rword(11'h005, 16'h3C3C);
    wreg(3'h7, 16'hFFFF);
    rreg(3'h7, v);
    chk("unmapped read", 16'h0000, v);
    wrap_up;
  end
endmodule
